// >>> design/sbc_mode_consts.svh
`ifndef SBC_MODE_CONSTS_SVH
`define SBC_MODE_CONSTS_SVH

// Register byte offsets on the Wishbone slave.
`define REG_CTRL_OFS 8'h00
`define REG_OSC_OFS 8'h04
`define REG_STAT_OFS 8'h08

// Control register fields and reset values.
`define CTRL_HV_BIT 0
`define CTRL_RST 1'h0
`define OSC_DIV_RST 16'h0F5A

// Status register field positions.
`define STAT_MODE_LSB 0
`define STAT_SRC_LSB 4
`define STAT_LH_BIT 8
`define STAT_NRES_BIT 9
`define STAT_WD_LSB 12
`define STAT_GOOD_LSB 16

// Synchronised input vector positions.
`define IN_LIN 0
`define IN_PREWAKE 1
`define IN_WK 2
`define IN_IGN 3
`define IN_EN 4
`define IN_TXD 5
`define IN_TRIG 6
`define IN_WDDIS 7
`define IN_VSOK 8
`define IN_VSUV 9
`define IN_VCCUV 10
`define IN_W 11

// Timing: clock and absolute times.
`define CLK_PERIOD_NS 10
`define T_TRIG_MIN_NS 200
`define T_REARM_US 10
`define T_RES_US 4000
`define TRIG_MIN_CYC ((`T_TRIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REARM_CYC ((`T_REARM_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Timing in internal oscillator periods.
`define T_LEAD_OSC 12'hF90
`define T_CLOSED_OSC 12'h20F
`define T_OPEN_OSC 12'h229
`define T_BUS_OSC 8'h03
`define LOCAL_WAKE_FILTER_TIME_OSC 8'h03
`define T_IGN_OSC 8'h03

`endif

// >>> design/sbc_mode_pkg.sv
package sbc_mode_pkg;

  // Operating modes of the chip.
  typedef enum logic [2:0] {
    MODE_UNPOWERED,
    MODE_FAILSAFE,
    MODE_NORMAL,
    MODE_SILENT,
    MODE_SLEEP
  } mode_t;

  // Source shown on the data pins in Fail-Safe.
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_BUS,
    SRC_LOCAL,
    SRC_UV
  } src_t;

  // Window watchdog phases.
  typedef enum logic [1:0] {
    WD_OFF,
    WD_LEAD,
    WD_CLOSED,
    WD_OPEN
  } wd_state_t;

endpackage

// >>> design/sbc_mode_wake_watchdog_ctrl.sv
// Functional notes
// - Sleep bus pulse longer than bus time wakes.
// - Bus wake enables regulator, termination, drives pins low.
// - Enable high leaves Sleep/Silent; then Normal after reset.
// - Filtered wake-pin low is a local wake request.
// - Local wake pulls transmit pin low.
// - Wake pin must idle high 10 us to rearm.
// - Debounced ignition high is a local wake request.
// - Ignition must idle low 10 us to rearm.
// - Fail-Safe pins encode bus, local or undervoltage source.
// - Source clears when Normal entered with enable high.
// - Power-up enters Fail-Safe, holds reset, blocks modes.
// - Sleep undervoltage ignores wakes; unpowered below threshold.
// - Silent regulator undervoltage goes Fail-Safe.
// - Normal supply undervoltage goes Fail-Safe, transceiver off.
// - Low-voltage variant: enable fall exits undervoltage Fail-Safe.
// - High-voltage variant: only Sleep exit under regulator undervoltage.
// - Trigger above 200 ns needed in window, else reset.
// - Watchdog off in Silent and Sleep, oscillator timebase.
// - Lead time starts at reset release or Silent wake.
// - Limp-home off at power-up, on at fault, three triggers.
// - Limp-home changes in Normal and Fail-Safe, holds in Silent, clears in Sleep or unpowered.
// - Limp-home disabled with watchdog disable, Sleep, unpowered.
// - Trigger in closed window forces reset and limp-home.
// - Low reset output forces Fail-Safe; 4 ms power-up hold.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "sbc_mode_consts.svh"
module sbc_mode_wake_watchdog_ctrl
  import sbc_mode_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC =
    `T_RES_US * 1000 / `CLK_PERIOD_NS
)(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and comparators from outside the clock domain.
  input wire logic lin_bus_i,
  input wire logic prewake_level_i,
  input wire logic local_wake_in_i,
  input wire logic ignition_sense_in_i,
  input wire logic en_i,
  input wire logic txd_i,
  input wire logic wdog_trigger_in_i,
  input wire logic wd_disable_i,
  input wire logic vs_op_ok_i,
  input wire logic vs_uv_i,
  input wire logic vcc_uv_i,
  // Data pins toward the host.
  output logic rxd_o,
  output logic txd_o,
  output logic txd_oe_o,
  output logic txd_strong_o,
  // Open-drain reset and limp-home pins.
  output logic nres_o,
  output logic nres_oe_o,
  output logic limp_home_out_o,
  output logic limp_home_out_oe_o,
  // Analog enables.
  output logic regulator_en_o,
  output logic termination_en_o,
  output logic transceiver_en_o,
  output logic lin_tx_o
);

  // Regulator runs in every mode except Sleep and Unpowered.
  function automatic logic powered(input mode_t m);
    powered = (m != MODE_SLEEP) && (m != MODE_UNPOWERED);
  endfunction

  logic [`IN_W-1:0] raw, s1_q, s2_q, s3_q, f_q, fp_q;
  mode_t mode_q, mode_d;
  src_t src_q, src_d;
  wd_state_t wd_q, wd_d;
  logic [11:0] wd_cnt_q, wd_cnt_d;
  logic [18:0] rst_cnt_q;
  logic [15:0] osc_div_q, osc_cnt_q;
  logic [4:0] trig_cnt_q;
  logic [7:0] dom_cnt_q;
  logic [1:0] good_q;
  logic [1:0] lw_fire;
  logic hv_q, lh_q, ack_q, bus_arm_q, bus_dom_q;
  logic [31:0] dat_q;
  logic tick, rst_busy, nres_low, en_fall, listen, bus_wake, trig;
  logic hold_start, wd_fault, good_inc, wd_active;
  logic rxd_d, txd_d, txd_oe_d, strong_d;
  logic rxd_q, txd_q, txd_oe_q, strong_q, nres_oe_q, lh_oe_q;
  logic reg_en_q, term_en_q, xcvr_en_q, lin_tx_q;

  // Every outside level passes three flops; a change counts once the
  // second and third agree, which rejects a single metastable sample.
  assign raw = {vcc_uv_i, vs_uv_i, vs_op_ok_i, wd_disable_i,
    wdog_trigger_in_i, txd_i, en_i, ignition_sense_in_i,
    local_wake_in_i, prewake_level_i, lin_bus_i};
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      fp_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fp_q <= f_q;
    end
  end
  for (genvar i = 0; i < `IN_W; i++)
  begin : g_filt
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        f_q[i] <= 1'b0;
      else if (s2_q[i] == s3_q[i])
        f_q[i] <= s3_q[i];
    end
  end

  // Oscillator timebase; software sets the period as the resistor would.
  assign tick = (osc_cnt_q == 16'h0000);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      osc_cnt_q <= 16'h0000;
    else if (tick)
      osc_cnt_q <= (osc_div_q == 16'h0000) ? 16'h0000 : osc_div_q - 16'h1;
    else
      osc_cnt_q <= osc_cnt_q - 16'h1;
  end

  // Wake detection only listens in the low-power modes.
  assign listen = (mode_q == MODE_SLEEP) || (mode_q == MODE_SILENT);
  assign en_fall = fp_q[`IN_EN] & ~f_q[`IN_EN];
  assign bus_wake = bus_dom_q & f_q[`IN_LIN] & ~fp_q[`IN_LIN] &
    (dom_cnt_q > `T_BUS_OSC);

  // Bus wake: arm below pre-wake level, time the dominant phase.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_arm_q <= 1'b0;
      bus_dom_q <= 1'b0;
      dom_cnt_q <= 8'h00;
    end
    else if (!listen)
    begin
      bus_arm_q <= 1'b0;
      bus_dom_q <= 1'b0;
      dom_cnt_q <= 8'h00;
    end
    else
    begin
      if (f_q[`IN_PREWAKE])
        bus_arm_q <= 1'b1;
      if (bus_arm_q && fp_q[`IN_LIN] && !f_q[`IN_LIN])
      begin
        bus_dom_q <= 1'b1;
        dom_cnt_q <= 8'h00;
      end
      else if (f_q[`IN_LIN])
        bus_dom_q <= 1'b0;
      else if (tick && dom_cnt_q != 8'hFF)
        dom_cnt_q <= dom_cnt_q + 8'h01;
    end
  end

  // Local wake channels: 0 is the wake pin (active low), 1 ignition.
  for (genvar c = 0; c < 2; c++)
  begin : g_lw
    logic act, act_p;
    logic armed_q;
    logic [9:0] idle_q;
    logic [7:0] filt_q;
    logic [7:0] need;
    assign act = (c == 0) ? ~f_q[`IN_WK] : f_q[`IN_IGN];
    assign act_p = (c == 0) ? ~fp_q[`IN_WK] : fp_q[`IN_IGN];
    assign need = (c == 0) ? `LOCAL_WAKE_FILTER_TIME_OSC : `T_IGN_OSC;
    assign lw_fire[c] = armed_q & act & tick & (filt_q == need);
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        armed_q <= 1'b0;
        idle_q <= 10'h000;
        filt_q <= 8'h00;
      end
      else
      begin
        if (act)
          idle_q <= 10'h000;
        else if (idle_q != 10'(`REARM_CYC))
          idle_q <= idle_q + 10'h001;
        if (act && !act_p)
        begin
          armed_q <= (idle_q == 10'(`REARM_CYC));
          filt_q <= 8'h00;
        end
        else if (!act || lw_fire[c])
          armed_q <= 1'b0;
        else if (tick && armed_q)
          filt_q <= filt_q + 8'h01;
      end
    end
  end

  // Mode sequencing.
  assign nres_low = rst_busy | f_q[`IN_VCCUV];
  always_comb
  begin
    mode_d = mode_q;
    src_d = src_q;
    hold_start = 1'b0;
    case (mode_q)
      MODE_UNPOWERED:
        if (f_q[`IN_VSOK])
        begin
          mode_d = MODE_FAILSAFE;
          hold_start = 1'b1;
        end
      MODE_FAILSAFE:
        if (en_fall && src_q == SRC_UV && !rst_busy)
        begin
          if (!f_q[`IN_TXD])
            mode_d = MODE_SLEEP;
          else if (!(hv_q && f_q[`IN_VCCUV]))
            mode_d = MODE_SILENT;
        end
        else if (f_q[`IN_EN] && !nres_low && !f_q[`IN_VSUV])
        begin
          mode_d = MODE_NORMAL;
          src_d = SRC_NONE;
        end
      MODE_NORMAL:
        if (f_q[`IN_VSUV])
        begin
          mode_d = MODE_FAILSAFE;
          src_d = SRC_UV;
        end
        else if (nres_low)
          mode_d = MODE_FAILSAFE;
        else if (en_fall)
          mode_d = f_q[`IN_TXD] ? MODE_SILENT : MODE_SLEEP;
      MODE_SILENT:
        if (nres_low || f_q[`IN_EN])
          mode_d = MODE_FAILSAFE;
        else if (bus_wake)
        begin
          mode_d = MODE_FAILSAFE;
          src_d = SRC_BUS;
        end
        else if (|lw_fire)
        begin
          mode_d = MODE_FAILSAFE;
          src_d = SRC_LOCAL;
        end
      MODE_SLEEP:
        if (f_q[`IN_EN])
        begin
          mode_d = MODE_FAILSAFE;
          hold_start = 1'b1;
        end
        else if (!f_q[`IN_VSUV] && (bus_wake || (|lw_fire)))
        begin
          mode_d = MODE_FAILSAFE;
          src_d = bus_wake ? SRC_BUS : SRC_LOCAL;
          hold_start = 1'b1;
        end
      default:
        mode_d = MODE_UNPOWERED;
    endcase
    if (!f_q[`IN_VSOK])
      mode_d = MODE_UNPOWERED;
  end

  // Trigger qualification: a low must last the minimum pulse width.
  assign trig = !f_q[`IN_TRIG] &&
    (trig_cnt_q == 5'(`TRIG_MIN_CYC - 1));

  // Window watchdog; it only runs with the reset output released, so
  // the lead phase starts at that release or at a Silent wake.
  assign wd_active = (mode_q == MODE_NORMAL || mode_q == MODE_FAILSAFE) &&
    !f_q[`IN_WDDIS] && !nres_low;
  always_comb
  begin
    wd_d = wd_q;
    wd_cnt_d = wd_cnt_q;
    wd_fault = 1'b0;
    good_inc = 1'b0;
    if (!wd_active)
    begin
      wd_d = WD_OFF;
      wd_cnt_d = 12'h000;
    end
    else
      case (wd_q)
        WD_OFF:
          wd_d = WD_LEAD;
        WD_LEAD:
          if (trig)
          begin
            wd_d = WD_CLOSED;
            wd_cnt_d = 12'h000;
          end
          else if (tick)
          begin
            wd_fault = (wd_cnt_q == `T_LEAD_OSC - 12'h1);
            wd_cnt_d = wd_cnt_q + 12'h001;
          end
        WD_CLOSED:
          if (trig)
            wd_fault = 1'b1;
          else if (tick && wd_cnt_q == `T_CLOSED_OSC - 12'h1)
          begin
            wd_d = WD_OPEN;
            wd_cnt_d = 12'h000;
          end
          else if (tick)
            wd_cnt_d = wd_cnt_q + 12'h001;
        WD_OPEN:
          if (trig)
          begin
            wd_d = WD_CLOSED;
            wd_cnt_d = 12'h000;
            good_inc = 1'b1;
          end
          else if (tick)
          begin
            wd_fault = (wd_cnt_q == `T_OPEN_OSC - 12'h1);
            wd_cnt_d = wd_cnt_q + 12'h001;
          end
        default:
          wd_d = WD_OFF;
      endcase
    if (wd_fault)
      wd_d = WD_OFF;
  end

  // State registers; the reset hold counter makes the reset output low.
  assign rst_busy = (rst_cnt_q != 19'h00000);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= MODE_UNPOWERED;
      src_q <= SRC_NONE;
      wd_q <= WD_OFF;
      wd_cnt_q <= 12'h000;
      rst_cnt_q <= 19'h00000;
      trig_cnt_q <= 5'h00;
    end
    else
    begin
      mode_q <= mode_d;
      src_q <= src_d;
      wd_q <= wd_d;
      wd_cnt_q <= wd_cnt_d;
      if (hold_start || wd_fault)
        rst_cnt_q <= 19'(RESET_HOLD_CYC);
      else if (rst_busy)
        rst_cnt_q <= rst_cnt_q - 19'h00001;
      if (f_q[`IN_TRIG])
        trig_cnt_q <= 5'h00;
      else if (trig_cnt_q != 5'(`TRIG_MIN_CYC))
        trig_cnt_q <= trig_cnt_q + 5'h01;
    end
  end

  // Limp-home: set at a watchdog fault, cleared after three good
  // triggers; frozen in Silent because the watchdog cannot act there.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lh_q <= 1'b0;
      good_q <= 2'h0;
    end
    else if (!powered(mode_q))
    begin
      lh_q <= 1'b0;
      good_q <= 2'h0;
    end
    else if (wd_fault)
    begin
      lh_q <= 1'b1;
      good_q <= 2'h0;
    end
    else if (good_inc && lh_q)
    begin
      good_q <= (good_q == 2'h2) ? 2'h0 : good_q + 2'h1;
      lh_q <= (good_q != 2'h2);
    end
  end

  // Pin values per mode and source.
  always_comb
  begin
    rxd_d = 1'b1;
    txd_d = 1'b1;
    txd_oe_d = 1'b0;
    strong_d = 1'b0;
    case (mode_q)
      MODE_FAILSAFE:
        case (src_q)
          SRC_BUS:
          begin
            rxd_d = 1'b0;
            txd_d = 1'b0;
            txd_oe_d = 1'b1;
            strong_d = 1'b1;
          end
          SRC_LOCAL:
          begin
            txd_d = 1'b0;
            txd_oe_d = 1'b1;
          end
          SRC_UV:
          begin
            rxd_d = 1'b0;
            txd_oe_d = 1'b1;
          end
          default:
            rxd_d = 1'b1;
        endcase
      MODE_NORMAL:
        rxd_d = f_q[`IN_LIN];
      MODE_SLEEP, MODE_UNPOWERED:
        rxd_d = 1'b0;
      default:
        rxd_d = 1'b1;
    endcase
  end

  // Output flops keep pin data glitch free.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {rxd_q, txd_q, txd_oe_q, strong_q} <= 4'h0;
      {nres_oe_q, lh_oe_q, lin_tx_q} <= 3'h5;
      {reg_en_q, term_en_q, xcvr_en_q} <= 3'h0;
    end
    else
    begin
      {rxd_q, txd_q, txd_oe_q, strong_q} <=
        {rxd_d, txd_d, txd_oe_d, strong_d};
      nres_oe_q <= nres_low || !powered(mode_q);
      lh_oe_q <= lh_q && !f_q[`IN_WDDIS] && powered(mode_q);
      lin_tx_q <= (mode_q == MODE_NORMAL) ? f_q[`IN_TXD] : 1'b1;
      reg_en_q <= powered(mode_q);
      term_en_q <= (mode_q == MODE_FAILSAFE) || (mode_q == MODE_NORMAL);
      xcvr_en_q <= (mode_q == MODE_NORMAL);
    end
  end
  assign rxd_o = rxd_q;
  assign txd_o = txd_q;
  assign txd_oe_o = txd_oe_q;
  assign txd_strong_o = strong_q;
  assign nres_o = 1'b0;
  assign nres_oe_o = nres_oe_q;
  assign limp_home_out_o = 1'b0;
  assign limp_home_out_oe_o = lh_oe_q;
  assign regulator_en_o = reg_en_q;
  assign termination_en_o = term_en_q;
  assign transceiver_en_o = xcvr_en_q;
  assign lin_tx_o = lin_tx_q;

  // Wishbone slave: ack one cycle after the strobe; writes land on the
  // acknowledged edge, and unmapped addresses read zero.
  logic wb_req, hit_ctrl, hit_osc, hit_stat, wr_en;
  logic [31:0] rd_mux, stat_w;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign hit_ctrl = (wb_adr_i == `REG_CTRL_OFS);
  assign hit_osc = (wb_adr_i == `REG_OSC_OFS);
  assign hit_stat = (wb_adr_i == `REG_STAT_OFS);
  assign wr_en = wb_req & ack_q & wb_we_i;
  assign stat_w = (32'(mode_q) << `STAT_MODE_LSB) |
    (32'(src_q) << `STAT_SRC_LSB) | (32'(lh_q) << `STAT_LH_BIT) |
    (32'(nres_low) << `STAT_NRES_BIT) | (32'(wd_q) << `STAT_WD_LSB) |
    (32'(good_q) << `STAT_GOOD_LSB);
  assign rd_mux = hit_ctrl ? {31'h0, hv_q} :
    hit_osc ? {16'h0000, osc_div_q} : hit_stat ? stat_w : 32'h0;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      hv_q <= `CTRL_RST;
      osc_div_q <= `OSC_DIV_RST;
    end
    else
    begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req && !ack_q)
        dat_q <= rd_mux;
      if (wr_en && hit_ctrl && wb_sel_i[0])
        hv_q <= wb_dat_i[`CTRL_HV_BIT];
      if (wr_en && hit_osc && wb_sel_i[0])
        osc_div_q[7:0] <= wb_dat_i[7:0];
      if (wr_en && hit_osc && wb_sel_i[1])
        osc_div_q[15:8] <= wb_dat_i[15:8];
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Checks.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_powerup;
    mode_q == MODE_UNPOWERED && f_q[`IN_VSOK];
  endsequence
  sequence s_hold_low;
    nres_oe_o [*8];
  endsequence

  AST_BUS_WAKE:
    assert property (bus_wake && mode_q == MODE_SLEEP && !f_q[`IN_VSUV]
      && f_q[`IN_VSOK] && !f_q[`IN_EN] |=> mode_q == MODE_FAILSAFE)
    else $error("bus wake did not reach Fail-Safe");
  AST_BUS_PINS:
    assert property (mode_q == MODE_FAILSAFE && src_q == SRC_BUS |=>
      txd_oe_o && !txd_o && txd_strong_o && !rxd_o && regulator_en_o)
    else $error("bus wake pins wrong");
  AST_NORMAL_ENTRY:
    assert property (mode_q == MODE_FAILSAFE && f_q[`IN_EN] && !nres_low
      && f_q[`IN_VSOK] && !f_q[`IN_VSUV] |=> mode_q == MODE_NORMAL)
    else $error("Normal not entered");
  AST_LOCAL_WAKE:
    assert property (lw_fire[0] && mode_q == MODE_SILENT && f_q[`IN_VSOK]
      |=> mode_q == MODE_FAILSAFE ##1 termination_en_o)
    else $error("local wake lost");
  AST_LOCAL_PINS:
    assert property (mode_q == MODE_FAILSAFE && src_q == SRC_LOCAL |=>
      txd_oe_o && !txd_o && rxd_o)
    else $error("local source pins wrong");
  AST_SRC_CLEAR:
    assert property (mode_q == MODE_NORMAL |-> src_q == SRC_NONE)
    else $error("source kept in Normal");
  AST_POWERUP_HOLD:
    assert property (s_powerup |=> ##1 s_hold_low)
    else $error("reset not held at power-up");
  AST_CLOSED_TRIG:
    assert property (wd_q == WD_CLOSED && trig && wd_active |->
      ##2 nres_oe_o && limp_home_out_oe_o)
    else $error("closed window trigger ignored");
  AST_WD_SILENT:
    assert property (mode_q == MODE_SILENT |=> wd_q == WD_OFF)
    else $error("watchdog runs in Silent");
  AST_LH_SILENT:
    assert property (mode_q == MODE_SILENT && $past(mode_q) == MODE_SILENT
      |-> $stable(lh_q))
    else $error("limp-home changed in Silent");

endmodule

// >>> tb/host_mcu_model.sv
`timescale 1ns/1ps
// Host controller model. It drives enable, transmit data and the trigger,
// and changes each of them just after a rising edge.
module host_mcu_model (
  // Clock.
  input wire logic clk_sys_i,
  // Pins toward the chip.
  output logic en_o,
  output logic txd_o,
  output logic trig_n_o
);
  // Idle levels: enable low, transmit recessive, trigger released.
  initial
  begin
    en_o = 1'b0;
    txd_o = 1'b1;
    trig_n_o = 1'b1;
  end

  // A steady high on enable asks for Normal mode.
  task automatic go_normal();
    @(posedge clk_sys_i);
    en_o <= 1'b1;
  endtask

  // Transmit level goes first, so the enable fall selects Silent or Sleep.
  task automatic leave_normal(input logic lvl);
    @(posedge clk_sys_i);
    txd_o <= lvl;
    @(posedge clk_sys_i);
    en_o <= 1'b0;
  endtask

  // Plain transmit level while the transceiver is on.
  task automatic set_txd(input logic lvl);
    @(posedge clk_sys_i);
    txd_o <= lvl;
  endtask

  // A 300 ns low pulse, long enough to pass the glitch filter.
  task automatic pulse();
    @(posedge clk_sys_i);
    trig_n_o <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    trig_n_o <= 1'b1;
  endtask
endmodule

// >>> tb/sbc_mode_wake_watchdog_ctrl_test.sv
`timescale 1ns/1ps
`include "sbc_mode_consts.svh"
// Bench top. The expected mode and source are compared with the status word.
module sbc_mode_wake_watchdog_ctrl_test
  import sbc_mode_pkg::*;
;
  // Stimulus, observed outputs and counters.
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o;
  logic lin = 1'b1, prew = 1'b0, wake = 1'b1, ign = 1'b0;
  logic wdd = 1'b0, vsok = 1'b0, vsuv = 1'b0, vccuv = 1'b0;
  logic [3:0] sel = 4'hF;
  logic en, txd_h, trig, txd_w;
  logic rxd, txd_d, txd_oe, txd_st, nres_oe, lh_oe, reg_en, term_en;
  logic trx_en, lin_tx, nres_lvl, lh_lvl;
  int n_mismatch = 0, num_checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  // Either party may pull the transmit wire low; the chip's transmit input sees the result.
  assign txd_w = txd_h & ~(txd_oe & ~txd_d);

  // Design with a short reset hold, so each wake costs few cycles.
  sbc_mode_wake_watchdog_ctrl #(.RESET_HOLD_CYC(50)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .lin_bus_i(lin), .prewake_level_i(prew),
    .local_wake_in_i(wake), .ignition_sense_in_i(ign), .en_i(en),
    .txd_i(txd_w), .wdog_trigger_in_i(trig), .wd_disable_i(wdd),
    .vs_op_ok_i(vsok), .vs_uv_i(vsuv), .vcc_uv_i(vccuv), .rxd_o(rxd),
    .txd_o(txd_d), .txd_oe_o(txd_oe), .txd_strong_o(txd_st),
    .nres_o(nres_lvl), .nres_oe_o(nres_oe), .limp_home_out_o(lh_lvl),
    .limp_home_out_oe_o(lh_oe), .regulator_en_o(reg_en),
    .termination_en_o(term_en), .transceiver_en_o(trx_en),
    .lin_tx_o(lin_tx)
  );

  // Host controller on the far side of the pins.
  host_mcu_model i_host (
    .clk_sys_i(clk_sys_i), .en_o(en), .txd_o(txd_h), .trig_n_o(trig)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic bus cycle; the request holds until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_sys_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k == 20)
    begin
      n_mismatch++;
      $display("BAD t=%0t no acknowledge", $time);
      stop_test();
    end
  endtask

  // Polls the status word; the bound covers a full watchdog lead time.
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    num_checks++;
    repeat (6000)
    begin
      wb(1'b0, `REG_STAT_OFS, 32'h0, s);
      if ((s & m) === v)
        return;
    end
    n_mismatch++;
    $display("BAD t=%0t status never reached %h", $time, v);
    stop_test();
  endtask

  // Waits for a mode, then compares mode and source with the expectation.
  task automatic step(input mode_t m, input src_t s);
    logic [31:0] d;
    wait_stat(32'h7, {29'h0, m});
    wb(1'b0, `REG_STAT_OFS, 32'h0, d);
    chk({26'h0, d[5:4], 1'b0, d[2:0]}, {26'h0, s, 1'b0, m});
  endtask

  // Remote node sends a dominant pulse, crossing the pre-wake level first.
  task automatic bus_pulse(input int n);
    @(posedge clk_sys_i);
    prew <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    lin <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    lin <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    prew <= 1'b0;
  endtask

  // Hang guard for the whole run.
  initial
  begin
    #900000;
    n_mismatch++;
    $display("BAD t=%0t run timed out", $time);
    stop_test();
  end

  // Main sequence.
  initial
  begin
    logic [31:0] d;
    int n;
    void'($urandom(12));
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wb(1'b0, `REG_CTRL_OFS, 32'h0, d);
    chk(d, 32'h0);
    wb(1'b0, `REG_OSC_OFS, 32'h0, d);
    chk(d, {16'h0, `OSC_DIV_RST});
    wb(1'b1, 8'h0C, 32'hFFFF, d);
    wb(1'b0, 8'h0C, 32'h0, d);
    chk(d, 32'h0);
    sel <= 4'h2;
    wb(1'b1, `REG_OSC_OFS, 32'h2, d);
    sel <= 4'hF;
    wb(1'b0, `REG_OSC_OFS, 32'h0, d);
    chk(d, {24'h0, 8'(`OSC_DIV_RST)});
    wb(1'b1, `REG_OSC_OFS, 32'h2, d);
    wb(1'b0, `REG_OSC_OFS, 32'h0, d);
    chk(d, 32'h2);
    step(MODE_UNPOWERED, SRC_NONE);
    $display("registers done");
    vsok <= 1'b1;
    step(MODE_FAILSAFE, SRC_NONE);
    chk(32'(nres_oe), 32'h1);
    i_host.go_normal();
    wb(1'b0, `REG_STAT_OFS, 32'h0, d);
    chk(d & 32'h7, 32'h1);
    step(MODE_NORMAL, SRC_NONE);
    repeat (4)
    begin
      n = $urandom % 2;
      i_host.set_txd(n[0]);
      repeat (8) @(posedge clk_sys_i);
      chk({30'h0, trx_en, lin_tx}, {30'h0, 1'b1, n[0]});
    end
    i_host.set_txd(1'b1);
    $display("power-up done");
    // No trigger at all: the lead time runs out into a watchdog reset.
    wait_stat(32'h300, 32'h300);
    chk(32'(lh_oe), 32'h1);
    chk({30'h0, nres_lvl, lh_lvl}, 32'h0);
    step(MODE_NORMAL, SRC_NONE);
    i_host.pulse();
    repeat (3)
    begin
      repeat (1300) @(posedge clk_sys_i);
      i_host.pulse();
    end
    repeat (10) @(posedge clk_sys_i);
    chk({30'h0, lh_oe, nres_oe}, 32'h0);
    repeat (100) @(posedge clk_sys_i);
    i_host.pulse();
    repeat (4) @(posedge clk_sys_i);
    chk({30'h0, lh_oe, nres_oe}, 32'h3);
    wdd <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk(32'(lh_oe), 32'h0);
    wdd <= 1'b0;
    $display("watchdog done");
    step(MODE_NORMAL, SRC_NONE);
    i_host.leave_normal(1'b0);
    step(MODE_SLEEP, SRC_NONE);
    chk({29'h0, reg_en, lh_oe, rxd}, 32'h0);
    bus_pulse(20 + $urandom % 20);
    step(MODE_FAILSAFE, SRC_BUS);
    chk({26'h0, txd_oe, txd_d, txd_st, rxd, reg_en, term_en},
        32'h2B);
    $display("bus wake done");
    i_host.go_normal();
    step(MODE_NORMAL, SRC_NONE);
    i_host.leave_normal(1'b1);
    step(MODE_SILENT, SRC_NONE);
    vccuv <= 1'b1;
    step(MODE_FAILSAFE, SRC_NONE);
    chk(32'(nres_oe), 32'h1);
    vccuv <= 1'b0;
    i_host.go_normal();
    step(MODE_NORMAL, SRC_NONE);
    i_host.leave_normal(1'b1);
    step(MODE_SILENT, SRC_NONE);
    wake <= 1'b0;
    step(MODE_FAILSAFE, SRC_LOCAL);
    chk({28'h0, txd_oe, txd_d, rxd, term_en}, 32'hB);
    i_host.go_normal();
    step(MODE_NORMAL, SRC_NONE);
    i_host.leave_normal(1'b1);
    step(MODE_SILENT, SRC_NONE);
    // A short high on the wake pin must not rearm it.
    wake <= 1'b1;
    repeat (300) @(posedge clk_sys_i);
    wake <= 1'b0;
    repeat (100) @(posedge clk_sys_i);
    step(MODE_SILENT, SRC_NONE);
    wake <= 1'b1;
    repeat (1100) @(posedge clk_sys_i);
    wake <= 1'b0;
    step(MODE_FAILSAFE, SRC_LOCAL);
    wake <= 1'b1;
    $display("local wake done");
    i_host.go_normal();
    step(MODE_NORMAL, SRC_NONE);
    i_host.leave_normal(1'b0);
    step(MODE_SLEEP, SRC_NONE);
    ign <= 1'b1;
    step(MODE_FAILSAFE, SRC_LOCAL);
    chk(32'(term_en), 32'h1);
    ign <= 1'b0;
    $display("ignition done");
    i_host.go_normal();
    step(MODE_NORMAL, SRC_NONE);
    vsuv <= 1'b1;
    step(MODE_FAILSAFE, SRC_UV);
    chk({28'h0, trx_en, reg_en, txd_d, rxd}, 32'h6);
    wb(1'b1, `REG_CTRL_OFS, 32'h1, d);
    vccuv <= 1'b1;
    i_host.leave_normal(1'b1);
    repeat (10) @(posedge clk_sys_i);
    step(MODE_FAILSAFE, SRC_UV);
    i_host.go_normal();
    repeat (10) @(posedge clk_sys_i);
    i_host.leave_normal(1'b0);
    wait_stat(32'h7, 32'h4);
    bus_pulse(30);
    wb(1'b0, `REG_STAT_OFS, 32'h0, d);
    chk(d & 32'h7, 32'h4);
    vsok <= 1'b0;
    wait_stat(32'h7, 32'h0);
    $display("undervoltage done");
    stop_test();
  end
endmodule
